/* File: hdl/branch_skip_condition_unit.sv */
// Operation
// RULE1 - skip when general register bit is one
// RULE2 - skip when io register bit is zero
// RULE3 - skip when io register bit is one
// RULE4 - branch when indexed flag is one
// RULE5 - branch when indexed flag is zero
// RULE6 - branch same or higher when carry clear
// RULE7 - branch signed ge when n xor v zero
// RULE8 - branch signed lt when n xor v one
// RULE9 - branch when half carry is one
// RULE10 - offset k is signed two's complement
// RULE11 - skip two or three by next length
`timescale 1ns/1ps
`default_nettype none
module branch_skip_condition_unit
  import bsc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // decoder request
  input wire logic i_valid,
  input var instr_t i_instr,
  input wire logic [7:0] i_status_flags,
  output logic o_ready,
  // program counter, completion and taken result
  output logic [PC_W-1:0] o_pc,
  output logic o_done,
  output logic o_taken
);
  // ---------------------------------------------------------------
  // condition evaluation
  // ---------------------------------------------------------------
  logic cond;
  logic is_skip;
  logic [PC_W-1:0] k_ext;
  always_comb begin
    cond = 1'b0;
    is_skip = 1'b0;
    case (i_instr.op)
      OP_SKIP_REG_BIT_SET: begin
        cond = i_instr.operand[i_instr.bit_sel]; // RULE1
        is_skip = 1'b1;
      end
      OP_SKIP_IO_BIT_CLEAR: begin
        cond = ~i_instr.operand[i_instr.bit_sel]; // RULE2
        is_skip = 1'b1;
      end
      OP_SKIP_IO_BIT_SET: begin
        cond = i_instr.operand[i_instr.bit_sel]; // RULE3
        is_skip = 1'b1;
      end
      OP_BRANCH_FLAG_SET: cond = i_status_flags[i_instr.bit_sel]; // RULE4
      OP_BRANCH_FLAG_CLEAR: cond = ~i_status_flags[i_instr.bit_sel]; // RULE5
      OP_BRANCH_SAME_OR_HIGHER: cond = ~i_status_flags[FLAG_C]; // RULE6
      OP_BRANCH_SIGNED_GE: cond = ~(i_status_flags[FLAG_N] ^ i_status_flags[FLAG_V]); // RULE7
      OP_BRANCH_SIGNED_LT: cond = i_status_flags[FLAG_N] ^ i_status_flags[FLAG_V]; // RULE8
      OP_BRANCH_HALF_CARRY_SET: cond = i_status_flags[FLAG_H]; // RULE9
      default: cond = 1'b0;
    endcase
  end
  // sign extension lets branches reach backward as well as forward
  assign k_ext = {{(PC_W-K_W){i_instr.offset[K_W-1]}}, i_instr.offset}; // RULE10

  // ---------------------------------------------------------------
  // program counter and cycle sequencing
  // ---------------------------------------------------------------
  state_t state_ff, nxt_state;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [1:0] wait_ff, nxt_wait;
  logic taken_ff, nxt_taken;
  logic done_ff, nxt_done;
  logic accept;
  logic [1:0] cycles;
  assign accept = i_valid && (state_ff == ST_IDLE) && (i_instr.op != OP_NONE);
  assign o_ready = (state_ff == ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_wait = wait_ff;
    nxt_taken = taken_ff;
    nxt_done = 1'b0;
    cycles = CYC_ONE;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_taken = cond;
          if (!cond) begin
            nxt_pc = pc_ff + PC_STEP_ONE;
          end else if (is_skip) begin
            nxt_pc = pc_ff + (i_instr.next_is_long ? PC_STEP_SKIP2 : PC_STEP_SKIP1); // RULE11
            cycles = i_instr.next_is_long ? CYC_THREE : CYC_TWO; // RULE11
          end else begin
            nxt_pc = pc_ff + k_ext + PC_STEP_ONE; // RULE4
            cycles = CYC_TWO;
          end
          if (cycles == CYC_ONE) begin
            nxt_done = 1'b1;
          end else begin
            nxt_wait = cycles - CYC_ONE;
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        nxt_wait = wait_ff - CYC_ONE;
        if (wait_ff == CYC_ONE) begin
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      pc_ff <= PC_RESET;
      wait_ff <= 2'h0;
      taken_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      wait_ff <= nxt_wait;
      taken_ff <= nxt_taken;
      done_ff <= nxt_done;
    end
  end

  assign o_pc = pc_ff;
  assign o_done = done_ff;
  assign o_taken = taken_ff;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // the offset needs room above it in the counter for its sign
  if (PC_W <= K_W) begin : g_bad_width
    $error("pc width must exceed offset width");
  end
  if (FLAG_C > 7 || FLAG_N > 7 || FLAG_V > 7 || FLAG_H > 7) begin : g_bad_flag
    $error("flag position outside the status byte");
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_acc(op_t o);
    accept && i_instr.op == o;
  endsequence

  // one quiet cycle, then the finishing pulse
  sequence s_two_cycle;
    !done_ff ##1 done_ff;
  endsequence

  sequence s_three_cycle;
    !done_ff [*2] ##1 done_ff;
  endsequence

  // ---------------------------------------------------------------
  // decision checks; the io set skip is checked by its counter advance
  // ---------------------------------------------------------------
  a_skip_reg_set: assert property ( // RULE1
    s_acc(OP_SKIP_REG_BIT_SET) |=> taken_ff == $past(i_instr.operand[i_instr.bit_sel]))
    else $error("reg bit skip decision wrong");
  a_skip_io_clr: assert property ( // RULE2
    s_acc(OP_SKIP_IO_BIT_CLEAR) |=> taken_ff != $past(i_instr.operand[i_instr.bit_sel]))
    else $error("io clear skip decision wrong");
  a_skip_io_set: assert property ( // RULE3
    accept && i_instr.op == OP_SKIP_IO_BIT_SET && cond |=>
      pc_ff == $past(pc_ff) + ($past(i_instr.next_is_long) ? PC_STEP_SKIP2 : PC_STEP_SKIP1))
    else $error("io set skip advance wrong");
  a_flag_set_dec: assert property ( // RULE4
    s_acc(OP_BRANCH_FLAG_SET) |=> taken_ff == $past(i_status_flags[i_instr.bit_sel]))
    else $error("flag set branch decision wrong");
  a_flag_clr_dec: assert property ( // RULE5
    s_acc(OP_BRANCH_FLAG_CLEAR) |=> taken_ff != $past(i_status_flags[i_instr.bit_sel]))
    else $error("flag clear branch decision wrong");
  a_same_higher: assert property ( // RULE6
    s_acc(OP_BRANCH_SAME_OR_HIGHER) |=> taken_ff == !$past(i_status_flags[FLAG_C]))
    else $error("same or higher decision wrong");
  a_signed_ge: assert property ( // RULE7
    s_acc(OP_BRANCH_SIGNED_GE) |=>
      taken_ff == !$past(i_status_flags[FLAG_N] ^ i_status_flags[FLAG_V]))
    else $error("signed ge decision wrong");
  a_signed_lt: assert property ( // RULE8
    s_acc(OP_BRANCH_SIGNED_LT) |=>
      taken_ff == $past(i_status_flags[FLAG_N] ^ i_status_flags[FLAG_V]))
    else $error("signed lt decision wrong");
  a_half_carry: assert property ( // RULE9
    s_acc(OP_BRANCH_HALF_CARRY_SET) |=> taken_ff == $past(i_status_flags[FLAG_H]))
    else $error("half carry decision wrong");

  // ---------------------------------------------------------------
  // counter and timing checks
  // ---------------------------------------------------------------
  // the target is rebuilt by a signed cast, not from the extension above
  a_branch_flag_pc: assert property ( // RULE4
    accept && !is_skip && cond |=>
      pc_ff == $past(pc_ff) + PC_W'($signed($past(i_instr.offset))) + PC_STEP_ONE)
    else $error("taken branch target wrong");
  a_branch_time: assert property ( // RULE5
    accept && !is_skip && cond |=> s_two_cycle)
    else $error("taken branch not two cycles");
  a_not_taken: assert property ( // RULE6
    accept && !cond |=> done_ff && pc_ff == $past(pc_ff) + PC_STEP_ONE)
    else $error("fall through not one cycle");
  a_short_skip: assert property ( // RULE11
    accept && is_skip && cond && !i_instr.next_is_long |=>
      pc_ff == $past(pc_ff) + PC_STEP_SKIP1 ##0 s_two_cycle)
    else $error("short skip not two words two cycles");
  a_long_skip: assert property ( // RULE11
    accept && is_skip && cond && i_instr.next_is_long |=>
      pc_ff == $past(pc_ff) + PC_STEP_SKIP2 ##0 s_three_cycle)
    else $error("long skip not three words three cycles");
  a_busy_hold: assert property ( // RULE11
    state_ff == ST_WAIT |=> pc_ff == $past(pc_ff) && taken_ff == $past(taken_ff))
    else $error("state changed while busy");
  a_idle_hold: assert property ( // RULE4
    o_ready && !accept |=> pc_ff == $past(pc_ff) && !done_ff)
    else $error("idle cycle moved the counter");
  a_wait_count: assert property ( // RULE11
    state_ff == ST_WAIT |-> wait_ff == CYC_ONE || wait_ff == CYC_TWO)
    else $error("wait count out of range");
endmodule // branch_skip_condition_unit
`default_nettype wire

/* File: hdl/bsc_pkg.sv */
`default_nettype none
package bsc_pkg;
  // ---------------------------------------------------------------
  // operation codes presented by the decoder
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SKIP_REG_BIT_SET = 4'h1,
    OP_SKIP_IO_BIT_CLEAR = 4'h2,
    OP_SKIP_IO_BIT_SET = 4'h3,
    OP_BRANCH_FLAG_SET = 4'h4,
    OP_BRANCH_FLAG_CLEAR = 4'h5,
    OP_BRANCH_SAME_OR_HIGHER = 4'h6,
    OP_BRANCH_SIGNED_GE = 4'h7,
    OP_BRANCH_SIGNED_LT = 4'h8,
    OP_BRANCH_HALF_CARRY_SET = 4'h9
  } op_t;

  // ---------------------------------------------------------------
  // status flag positions
  // ---------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;

  localparam int PC_W = 16;
  localparam int K_W = 7;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP_SKIP1 = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP_SKIP2 = 16'h0003;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef struct packed {
    op_t op;
    logic [2:0] bit_sel;
    logic [7:0] operand;
    logic [K_W-1:0] offset;
    logic next_is_long;
  } instr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1
  } state_t;
endpackage
`default_nettype wire

/* File: testbench/tb_branch_skip_condition_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_branch_skip_condition_unit;
  import bsc_pkg::*;
  logic i_clk, i_rst_n, i_valid, o_ready, o_done, o_taken;
  instr_t i_instr;
  logic [7:0] i_status_flags;
  logic [PC_W-1:0] o_pc, pc_exp;
  int mismatches, checks_done, cyc;

  branch_skip_condition_unit dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_instr(i_instr), .i_status_flags(i_status_flags), .o_ready(o_ready), .o_pc(o_pc),
    .o_done(o_done), .o_taken(o_taken));

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected step and cost come from the rules, not from the dut
  task automatic go(input op_t op, input logic [2:0] b, input logic [7:0] v,
    input logic [K_W-1:0] k, input logic lng, input logic [7:0] f, input logic tk);
    int w;
    logic skip;
    instr_t ins;
    skip = (op inside {OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET});
    ins.op = op;
    ins.bit_sel = b;
    ins.operand = v;
    ins.offset = k;
    ins.next_is_long = lng;
    @(negedge i_clk);
    check(o_done, 1'b0);
    i_valid = 1'b1;
    i_instr = ins;
    i_status_flags = f;
    @(negedge i_clk);
    i_valid = 1'b0;
    check(o_ready, !tk);
    w = 1;
    while (o_done !== 1'b1 && w < 8) begin
      @(negedge i_clk);
      w++;
    end
    check(w, !tk ? 1 : (skip ? (lng ? 3 : 2) : 2));
    check(o_taken, tk);
    pc_exp = pc_exp + (!tk ? 16'h0001 : skip ? (lng ? 16'h0003 : 16'h0002)
      : {{9{k[6]}}, k} + 16'h0001);
    check(o_pc, pc_exp);
  endtask

  task automatic print_verdict;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_skip;
    go(OP_SKIP_REG_BIT_SET, 3'h3, 8'h08, 7'h00, 1'b0, 8'h00, 1'b1);
    go(OP_SKIP_REG_BIT_SET, 3'h3, 8'hf7, 7'h00, 1'b0, 8'h00, 1'b0);
    go(OP_SKIP_REG_BIT_SET, 3'h7, 8'h80, 7'h00, 1'b1, 8'h00, 1'b1);
    go(OP_SKIP_IO_BIT_CLEAR, 3'h0, 8'hfe, 7'h00, 1'b1, 8'h00, 1'b1);
    go(OP_SKIP_IO_BIT_CLEAR, 3'h0, 8'h01, 7'h00, 1'b0, 8'h00, 1'b0);
    go(OP_SKIP_IO_BIT_SET, 3'h5, 8'h20, 7'h00, 1'b0, 8'h00, 1'b1);
    go(OP_SKIP_IO_BIT_SET, 3'h5, 8'hdf, 7'h00, 1'b1, 8'h00, 1'b0);
  endtask

  // walk every flag index, one-hot so a wrong index shows
  task automatic t_flag;
    for (int s = 0; s < 8; s++) begin
      go(OP_BRANCH_FLAG_SET, s[2:0], 8'h00, 7'h05, 1'b0, 8'h01 << s, 1'b1);
      go(OP_BRANCH_FLAG_CLEAR, s[2:0], 8'h00, 7'h05, 1'b0, 8'h01 << s, 1'b0);
      go(OP_BRANCH_FLAG_CLEAR, s[2:0], 8'h00, 7'h7f, 1'b0, ~(8'h01 << s), 1'b1);
    end
  endtask

  task automatic t_cond;
    go(OP_BRANCH_SAME_OR_HIGHER, 3'h0, 8'h00, 7'h40, 1'b0, 8'h01, 1'b0);
    go(OP_BRANCH_SAME_OR_HIGHER, 3'h0, 8'h00, 7'h40, 1'b0, 8'hfe, 1'b1);
    go(OP_BRANCH_SIGNED_GE, 3'h0, 8'h00, 7'h3f, 1'b0, 8'h0c, 1'b1);
    go(OP_BRANCH_SIGNED_GE, 3'h0, 8'h00, 7'h3f, 1'b0, 8'h04, 1'b0);
    go(OP_BRANCH_SIGNED_LT, 3'h0, 8'h00, 7'h41, 1'b0, 8'h08, 1'b1);
    go(OP_BRANCH_SIGNED_LT, 3'h0, 8'h00, 7'h41, 1'b0, 8'hf3, 1'b0);
    go(OP_BRANCH_HALF_CARRY_SET, 3'h0, 8'h00, 7'h10, 1'b0, 8'h20, 1'b1);
    go(OP_BRANCH_HALF_CARRY_SET, 3'h0, 8'h00, 7'h10, 1'b0, 8'hdf, 1'b0);
  endtask

  // a request held high while busy must be ignored until ready returns
  task automatic t_busy;
    instr_t ins;
    ins = '0;
    ins.op = OP_BRANCH_FLAG_SET;
    ins.offset = 7'h05;
    @(negedge i_clk);
    i_valid = 1'b1;
    i_instr = ins;
    i_status_flags = 8'h01;
    ins.op = OP_SKIP_REG_BIT_SET;
    ins.operand = 8'hff;
    ins.next_is_long = 1'b1;
    @(negedge i_clk);
    i_instr = ins;
    check(o_ready, 1'b0);
    @(negedge i_clk);
    i_valid = 1'b0;
    check(o_done, 1'b1);
    pc_exp = pc_exp + 16'h0006;
    check(o_pc, pc_exp);
  endtask

  // a reset in mid-run returns the counter to its start
  task automatic t_reset;
    @(negedge i_clk);
    i_rst_n = 1'b0;
    @(posedge i_clk);
    check(o_pc, PC_RESET);
    check(o_taken, 1'b0);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    pc_exp = PC_RESET;
    go(OP_BRANCH_FLAG_CLEAR, 3'h1, 8'h00, 7'h7e, 1'b0, 8'h00, 1'b1);
  endtask

  // an empty opcode must leave pc alone and never finish
  task automatic t_none;
    logic seen;
    instr_t ins;
    seen = 1'b0;
    ins.op = OP_NONE;
    ins.bit_sel = 3'h0;
    ins.operand = 8'hff;
    ins.offset = 7'h7f;
    ins.next_is_long = 1'b1;
    @(negedge i_clk);
    i_valid = 1'b1;
    i_instr = ins;
    repeat (4) begin
      @(negedge i_clk);
      seen = seen | o_done;
    end
    i_valid = 1'b0;
    check(seen, 1'b0);
    check(o_pc, pc_exp);
  endtask

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    i_rst_n = 1'b0;
    i_valid = 1'b0;
    i_instr = '0;
    i_status_flags = 8'h00;
    pc_exp = PC_RESET;
    repeat (12) @(posedge i_clk);
    check(o_pc, PC_RESET);
    check(o_ready, 1'b1);
    check(o_done, 1'b0);
    check(o_taken, 1'b0);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    t_skip();
    t_flag();
    t_cond();
    t_busy();
    t_reset();
    t_none();
    print_verdict();
  end
endmodule // tb_branch_skip_condition_unit
`default_nettype wire
